// ===== include/adc_ctrl_pkg.sv
// constants, field layout and types of the successive-approximation converter control
package adc_ctrl_pkg;
   // ----------------------------------------
   // register port
   // ----------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 3;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_ZERO = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_RESULT = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_ENABLES = 3'h4;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int unsigned CLKSEL_LO = 6;
   localparam int unsigned CHAN_LO = 3;
   localparam int unsigned GO_BIT = 2;
   localparam int unsigned ENABLE_BIT = 0;
   localparam int unsigned REFCFG_LO = 0;
   localparam int unsigned DONE_FLAG_BIT = 6;
   localparam int unsigned IRQ_EN_BIT = 6;
   localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
   localparam logic [2:0] CHAN_RST = 3'h0;
   localparam logic [2:0] REFCFG_RST = 3'h0;
   localparam logic [DATA_W-1:0] SAR_INIT = 8'h80;
   localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

   // ----------------------------------------
   // timing in half bit-conversion periods
   // ----------------------------------------
   localparam int unsigned CNT_W = 5;
   localparam logic [CNT_W-1:0] HALF_DIV2 = 5'h01;
   localparam logic [CNT_W-1:0] HALF_DIV8 = 5'h04;
   localparam logic [CNT_W-1:0] HALF_DIV32 = 5'h10;
   localparam logic [CNT_W-1:0] CONV_HALF_TICKS = 5'h13;
   localparam logic [CNT_W-1:0] FIRST_DECIDE = 5'h04;
   localparam logic [CNT_W-1:0] RECOVER_HALF_TICKS = 5'h04;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

   // ----------------------------------------
   // enumerations
   // ----------------------------------------
   typedef enum logic [1:0] {
      CLK_DIV2 = 2'b00,
      CLK_DIV8 = 2'b01,
      CLK_DIV32 = 2'b10,
      CLK_RC = 2'b11
   } conv_clk_sel_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONVERT = 2'b01,
      ST_RECOVER = 2'b10
   } conv_state_t;
endpackage

// ===== design/tad_divider.sv
// half bit-conversion-period tick generator
`timescale 1ns/1ps
module tad_divider (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic restart_i,
   input wire adc_ctrl_pkg::conv_clk_sel_t sel_i,
   input wire logic rc_tick_i,
   // tick out
   output logic half_tick_o
);
   import adc_ctrl_pkg::*;

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] half_len;

   // half period in system cycles for the chosen source
   always_comb begin
      unique case (sel_i)
         CLK_DIV2: half_len = HALF_DIV2;
         CLK_DIV8: half_len = HALF_DIV8;
         CLK_DIV32: half_len = HALF_DIV32;
         CLK_RC: half_len = HALF_DIV2;
      endcase
   end

   // restart keeps the first period whole after a start
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= CNT_ZERO;
      end else if (restart_i || cnt == half_len - CNT_ONE) begin
         cnt <= CNT_ZERO;
      end else begin
         cnt <= cnt + CNT_ONE;
      end
   end

   // internal rc pulses bypass the counter
   assign half_tick_o = !restart_i && ((sel_i == CLK_RC) ? rc_tick_i : (cnt == half_len - CNT_ONE));
endmodule // tad_divider

// ===== design/sar_step.sv
// successive-approximation trial register
`timescale 1ns/1ps
module sar_step #(
   parameter int unsigned WIDTH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic load_i,
   input wire logic decide_i,
   input wire logic comp_i,
   // trial code and settled value
   output logic [WIDTH-1:0] trial_o,
   output logic [WIDTH-1:0] final_o
);
   logic [WIDTH-1:0] mask;
   logic [WIDTH-1:0] kept;

   generate
      if (WIDTH < 2) begin : g_bad_width
         $error("sar_step width too small");
      end
   endgenerate

   // comparator low means the trial bit overshot
   assign kept = comp_i ? trial_o : (trial_o & ~mask);

   // one bit decided per step, msb first
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         trial_o <= '0;
         mask <= '0;
      end else if (load_i) begin
         mask <= {1'b1, {(WIDTH-1){1'b0}}};
         trial_o <= {1'b1, {(WIDTH-1){1'b0}}};
      end else if (decide_i) begin
         mask <= mask >> 1;
         trial_o <= kept | (mask >> 1);
      end
   end

   // value with the pending decision applied, for the last step
   assign final_o = decide_i ? kept : trial_o;
endmodule // sar_step

// ===== design/sar_adc_conversion_control.sv
// register file and sequencer of the 8-bit successive-approximation converter
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module sar_adc_conversion_control #(
   parameter int unsigned RESULT_W = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [adc_ctrl_pkg::ADDR_W-1:0] addr_i,
   input wire logic [adc_ctrl_pkg::DATA_W-1:0] wdata_i,
   input wire logic write_i,
   input wire logic read_i,
   output logic [adc_ctrl_pkg::DATA_W-1:0] rdata_o,
   // analog front end
   input wire logic comp_i,
   input wire logic rc_tick_i,
   output logic [1:0] channel_o,
   output logic mux_enable_o,
   output logic sample_o,
   output logic vref_external_o,
   output logic [3:0] analog_pins_o,
   output logic converter_on_o,
   output logic [RESULT_W-1:0] trial_o,
   // core side
   input wire logic sleep_i,
   input wire logic global_irq_enable_i,
   output logic irq_o,
   output logic wake_o,
   output logic vector_o
);
   import adc_ctrl_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   conv_state_t state;
   conv_clk_sel_t clk_sel;
   logic [2:0] channel;
   logic [2:0] ref_cfg;
   logic enable;
   logic done_flag;
   logic irq_enable;
   logic [RESULT_W-1:0] result;
   logic [CNT_W-1:0] ticks;
   logic half_tick;
   logic wr_ctrl0;
   logic start_pulse;
   logic abort_req;
   logic done_pulse;
   logic decide;
   logic [RESULT_W-1:0] sar_final;

   generate
      if (RESULT_W != DATA_W) begin : g_bad_result_w
         $error("result width must match the register width");
      end
   endgenerate

   // ----------------------------------------
   // request decode
   // ----------------------------------------
   assign wr_ctrl0 = write_i && addr_i == ADDR_CTRL_ZERO;

   // enable must already be on; a go in the enabling write is ignored
   assign start_pulse = wr_ctrl0 && state == ST_IDLE && enable && wdata_i[ENABLE_BIT] && wdata_i[GO_BIT];

   // software clear, disable, or sleep on a system-derived clock ends it early
   assign abort_req = state == ST_CONVERT &&
                      ((wr_ctrl0 && (!wdata_i[GO_BIT] || !wdata_i[ENABLE_BIT])) ||
                       (sleep_i && clk_sel != CLK_RC));

   // last half period closes the conversion
   assign done_pulse = state == ST_CONVERT && half_tick && ticks == CONV_HALF_TICKS - CNT_ONE && !abort_req;

   // decisions on every second half period after the sampling phase
   assign decide = state == ST_CONVERT && half_tick && ticks >= FIRST_DECIDE && !ticks[0];

   // ----------------------------------------
   // clock divider and sar register
   // ----------------------------------------
   // an abort restarts the count too, so the recovery wait is two whole periods
   tad_divider u_tad_divider (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(start_pulse || abort_req),
      .sel_i(clk_sel),
      .rc_tick_i(rc_tick_i),
      .half_tick_o(half_tick)
   );

   sar_step #(
      .WIDTH(RESULT_W)
   ) u_sar_step (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(start_pulse),
      .decide_i(decide),
      .comp_i(comp_i),
      .trial_o(trial_o),
      .final_o(sar_final)
   );

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   // clock, channel and enable fields of control register zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_sel <= CLK_DIV2;
         channel <= CHAN_RST;
         enable <= 1'b0;
      end else if (wr_ctrl0) begin
         clk_sel <= conv_clk_sel_t'(wdata_i[CLKSEL_LO +: 2]);
         channel <= wdata_i[CHAN_LO +: 3];
         enable <= wdata_i[ENABLE_BIT];
      end
   end

   // reference configuration in control register one
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_cfg <= REFCFG_RST;
      end else if (write_i && addr_i == ADDR_CTRL_ONE) begin
         ref_cfg <= wdata_i[REFCFG_LO +: 3];
      end
   end

   // interrupt enable in the peripheral enable register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_enable <= 1'b0;
      end else if (write_i && addr_i == ADDR_ENABLES) begin
         irq_enable <= wdata_i[IRQ_EN_BIT];
      end
   end

   // completion flag: hardware only sets, and a set beats a same-cycle clear
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         done_flag <= 1'b0;
      end else if (done_pulse) begin
         done_flag <= 1'b1;
      end else if (write_i && addr_i == ADDR_FLAGS) begin
         done_flag <= wdata_i[DONE_FLAG_BIT];
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // half-period counter, reused for the recovery wait
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ticks <= CNT_ZERO;
      end else if (start_pulse || abort_req) begin
         ticks <= CNT_ZERO;
      end else if (state != ST_IDLE && half_tick) begin
         ticks <= ticks + CNT_ONE;
      end
   end

   // idle, convert, recover after an abort
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start_pulse) begin
                  state <= ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (abort_req) begin
                  state <= ST_RECOVER;
               end else if (done_pulse) begin
                  state <= ST_IDLE;
               end
            end
            ST_RECOVER: begin
               // recovery runs out even if the clock stops in sleep only on rc pulses
               if (half_tick && ticks == RECOVER_HALF_TICKS - CNT_ONE) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // result only moves on a full conversion, never on an abort
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         result <= RESULT_RST;
      end else if (done_pulse) begin
         result <= sar_final;
      end
   end

   // ----------------------------------------
   // register read port
   // ----------------------------------------
   // one cycle latency, unmapped and unread cycles return zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= READ_ZERO;
      end else if (read_i) begin
         unique case (addr_i)
            ADDR_CTRL_ZERO: rdata_o <= {clk_sel, channel, state == ST_CONVERT, 1'b0, enable};
            ADDR_CTRL_ONE: rdata_o <= {5'h00, ref_cfg};
            ADDR_RESULT: rdata_o <= result;
            ADDR_FLAGS: rdata_o <= {1'b0, done_flag, 6'h00};
            ADDR_ENABLES: rdata_o <= {1'b0, irq_enable, 6'h00};
            default: rdata_o <= READ_ZERO;
         endcase
      end else begin
         rdata_o <= READ_ZERO;
      end
   end

   // ----------------------------------------
   // analog side
   // ----------------------------------------
   // reserved channel codes leave the multiplexer open
   assign channel_o = channel[1:0];
   assign mux_enable_o = enable && !channel[2];
   assign sample_o = enable && state == ST_IDLE;
   assign converter_on_o = enable;

   // external reference on the odd codes except the all-digital pair
   assign vref_external_o = ref_cfg[0] && !(ref_cfg[2] && ref_cfg[1]);

   // analog pin map, msb is input 3
   always_comb begin
      unique case (ref_cfg)
         3'h0, 3'h2: analog_pins_o = 4'hf;
         3'h1, 3'h3: analog_pins_o = 4'h7;
         3'h4: analog_pins_o = 4'hb;
         3'h5: analog_pins_o = 4'h3;
         3'h6, 3'h7: analog_pins_o = 4'h0;
      endcase
   end

   // ----------------------------------------
   // interrupt request and wake
   // ----------------------------------------
   assign irq_o = done_flag && irq_enable;
   assign wake_o = sleep_i && irq_o;
   assign vector_o = irq_o && global_irq_enable_i && !sleep_i;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   localparam int CONV_WAIT_MIN = 19;
   localparam int CONV_WAIT_MAX = 320;
   localparam int RECOVER_WAIT_MAX = 70;

   chk_done_effects: assert property (@(posedge clk_i) disable iff (rst_i)
      done_pulse |=> done_flag && state == ST_IDLE && result == $past(sar_final))
      else $error("completion did not load result and flag");

   chk_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      done_flag && !(write_i && addr_i == ADDR_FLAGS) |=> done_flag)
      else $error("completion flag dropped without a write");

   chk_flag_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      done_pulse && write_i && addr_i == ADDR_FLAGS |=> done_flag)
      else $error("flag clear beat a completion");

   chk_irq_gating: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o |-> done_flag && irq_enable)
      else $error("interrupt without flag and enable");

   chk_sleep_wake: assert property (@(posedge clk_i) disable iff (rst_i)
      sleep_i && done_flag && irq_enable |-> wake_o && !vector_o)
      else $error("no wake from sleep on interrupt");

   chk_vector_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      vector_o |-> global_irq_enable_i && irq_o)
      else $error("vector without global enable");

   chk_div2_length: assert property (@(posedge clk_i) disable iff (rst_i)
      start_pulse && wdata_i[CLKSEL_LO +: 2] == CLK_DIV2 && !sleep_i ##1 !abort_req [*8] |->
         ##[10:11] (done_pulse || abort_req))
      else $error("div2 conversion length wrong");

   chk_conv_bounded: assert property (@(posedge clk_i) disable iff (rst_i)
      start_pulse && wdata_i[CLKSEL_LO +: 2] != CLK_RC |->
         ##[CONV_WAIT_MIN:CONV_WAIT_MAX] (done_pulse || abort_req))
      else $error("conversion did not finish in time");

   chk_abort_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(result) |-> $past(done_pulse))
      else $error("result changed without completion");

   chk_recover_bound: assert property (@(posedge clk_i) disable iff (rst_i)
      abort_req && clk_sel != CLK_RC |=> state == ST_RECOVER ##[1:RECOVER_WAIT_MAX] state == ST_IDLE)
      else $error("recovery wait not bounded");

   chk_busy_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
      state == ST_CONVERT |-> enable)
      else $error("converting while disabled");

   chk_reserved_chan: assert property (@(posedge clk_i) disable iff (rst_i)
      channel[2] |-> !mux_enable_o)
      else $error("reserved channel routed");

   chk_start_loads: assert property (@(posedge clk_i) disable iff (rst_i)
      start_pulse |=> state == ST_CONVERT && trial_o == SAR_INIT)
      else $error("start did not load the first trial code");

   chk_sleep_abort: assert property (@(posedge clk_i) disable iff (rst_i)
      state == ST_CONVERT && sleep_i && clk_sel != CLK_RC |=> state == ST_RECOVER)
      else $error("sleep on a system clock did not abort");

   cov_full_conv: cover property (@(posedge clk_i) disable iff (rst_i) done_pulse);
   cov_abort: cover property (@(posedge clk_i) disable iff (rst_i) abort_req ##[1:RECOVER_WAIT_MAX] state == ST_IDLE);
   cov_wake: cover property (@(posedge clk_i) disable iff (rst_i) wake_o);
   cov_rc_conv: cover property (@(posedge clk_i) disable iff (rst_i) done_pulse && clk_sel == CLK_RC);
   cov_set_wins: cover property (@(posedge clk_i) disable iff (rst_i) done_pulse && write_i && addr_i == ADDR_FLAGS);
endmodule // sar_adc_conversion_control

// ===== dv/analog_front_model.sv
// behavioural analog mux, sample-hold, comparator and rc source
`timescale 1ns/1ps
module analog_front_model #(
   parameter int unsigned RC_HALF = 3
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // converter side
   input wire logic [1:0] channel_i,
   input wire logic mux_enable_i,
   input wire logic sample_i,
   input wire logic [7:0] trial_i,
   output logic comp_o,
   output logic rc_tick_o,
   // analog levels, input 0 in the low byte
   input wire logic [31:0] levels_i
);
   logic [7:0] held;
   logic [3:0] rc_cnt;

   // hold cap follows the routed input only while tracking
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         held <= 8'h5a;
      end else if (sample_i && mux_enable_i) begin
         held <= levels_i[channel_i*8 +: 8];
      end
   end

   // comparator: keep the trial bit while input is not below it
   assign comp_o = (held >= trial_i);

   // rc source runs free, it does not wait for a conversion
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rc_cnt <= 4'h0;
      end else begin
         rc_cnt <= (rc_cnt == 4'(RC_HALF - 1)) ? 4'h0 : rc_cnt + 4'h1;
      end
   end
   assign rc_tick_o = (rc_cnt == 4'h0);
endmodule // analog_front_model

// ===== dv/sar_adc_conversion_control_tb.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
module sar_adc_conversion_control_tb;
   import adc_ctrl_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [ADDR_W-1:0] addr_i = 3'h0;
   logic [DATA_W-1:0] wdata_i = 8'h00;
   logic write_i = 1'b0;
   logic read_i = 1'b0;
   logic sleep_i = 1'b0;
   logic global_irq_enable_i = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   logic comp_i, rc_tick_i, mux_enable_o, sample_o, vref_external_o, converter_on_o, irq_o, wake_o, vector_o;
   logic [1:0] channel_o;
   logic [3:0] analog_pins_o;
   logic [7:0] trial_o;
   logic [31:0] levels = 32'hff_7e_01_a5;
   logic [7:0] rd;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;

   sar_adc_conversion_control uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .comp_i(comp_i), .rc_tick_i(rc_tick_i),
      .channel_o(channel_o), .mux_enable_o(mux_enable_o), .sample_o(sample_o),
      .vref_external_o(vref_external_o), .analog_pins_o(analog_pins_o), .converter_on_o(converter_on_o),
      .trial_o(trial_o), .sleep_i(sleep_i), .global_irq_enable_i(global_irq_enable_i), .irq_o(irq_o),
      .wake_o(wake_o), .vector_o(vector_o));
   analog_front_model front (.clk_i(clk_i), .rst_i(rst_i), .channel_i(channel_o), .mux_enable_i(mux_enable_o),
      .sample_i(sample_o), .trial_i(trial_o), .comp_o(comp_i), .rc_tick_o(rc_tick_i), .levels_i(levels));

   // 50 mhz clock and a hang guard well above the longest run
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // bus and compare helpers
   // ----------------------------------------
   task automatic give_verdict();
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      write_i <= 1'b1;
      @(posedge clk_i);
      write_i <= 1'b0;
   endtask
   // data is taken once the answering edge has landed
   task automatic rdr(input logic [2:0] a);
      @(posedge clk_i);
      addr_i <= a;
      read_i <= 1'b1;
      @(posedge clk_i);
      read_i <= 1'b0;
      #1;
      rd = rdata_o;
   endtask
   function automatic logic [7:0] c0(input logic [1:0] sel, input int ch, input logic go, input logic en);
      return {sel, ch[2:0], go, 1'b0, en};
   endfunction

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      for (int a = 0; a < 8; a++) begin
         rdr(a[2:0]);
         check(rd, 8'h00, "reset or unmapped read");
      end
      check({converter_on_o, irq_o, 2'b00, analog_pins_o}, 8'h0f, "reset outputs");
   endtask
   // go without enable, then go inside the enabling write
   task automatic t_refused();
      wr(ADDR_CTRL_ZERO, c0(2'b00, 0, 1'b1, 1'b0));
      rdr(ADDR_CTRL_ZERO);
      check(rd, 8'h00, "go while disabled");
      wr(ADDR_CTRL_ZERO, c0(2'b00, 0, 1'b1, 1'b1));
      rdr(ADDR_CTRL_ZERO);
      check(rd, 8'h01, "go in enabling write");
      check({7'h0, converter_on_o}, 8'h01, "enable out");
   endtask
   task automatic t_ref_chan();
      logic ext;
      logic [3:0] pins;
      for (int r = 0; r < 8; r++) begin
         wr(ADDR_CTRL_ONE, 8'(r));
         #1;
         ext = r[0] && (r[2:1] != 2'b11);
         check({7'h0, vref_external_o}, {7'h0, ext}, "reference select");
         pins = (r[2:1] == 2'b11) ? 4'h0 : (r == 4) ? 4'hb : (r == 5) ? 4'h3 : r[0] ? 4'h7 : 4'hf;
         check({4'h0, analog_pins_o}, {4'h0, pins}, "pin map");
         rdr(ADDR_CTRL_ONE);
         check(rd, 8'(r), "reference readback");
      end
      wr(ADDR_CTRL_ONE, 8'h00);
      wr(ADDR_CTRL_ZERO, c0(2'b00, 5, 1'b0, 1'b1));
      #1;
      check({7'h0, mux_enable_o}, 8'h00, "reserved channel");
      rdr(ADDR_CTRL_ZERO);
      check(rd, c0(2'b00, 5, 1'b0, 1'b1), "reserved readback");
      wr(ADDR_CTRL_ZERO, c0(2'b00, 3, 1'b0, 1'b1));
      #1;
      check({7'h0, mux_enable_o}, 8'h01, "valid channel");
   endtask
   // h is the half period in clocks, 0 for the rc source
   task automatic t_convert(input logic [1:0] sel, input int ch, input int h);
      int n;
      wr(ADDR_CTRL_ZERO, c0(sel, ch, 1'b0, 1'b1));
      repeat (8) @(posedge clk_i);
      check({6'h0, channel_o}, 8'(ch), "channel routing");
      wr(ADDR_CTRL_ZERO, c0(sel, ch, 1'b1, 1'b1));
      if (h > 0) begin
         repeat (19 * h - 2) @(posedge clk_i);
         rdr(ADDR_CTRL_ZERO);
         check(rd, c0(sel, ch, 1'b1, 1'b1), "busy in last half period");
         rdr(ADDR_CTRL_ZERO);
      end else begin
         rd = 8'hff;
         for (n = 0; n < 200 && rd[GO_BIT] !== 1'b0; n++) rdr(ADDR_CTRL_ZERO);
      end
      check(rd, c0(sel, ch, 1'b0, 1'b1), "busy cleared");
      rdr(ADDR_RESULT);
      check(rd, levels[ch*8 +: 8], "result");
      rdr(ADDR_FLAGS);
      check(rd, 8'h40, "flag with irq disabled");
      check({7'h0, irq_o}, 8'h00, "irq masked");
      wr(ADDR_FLAGS, 8'h00);
   endtask
   // rc conversion finishing in sleep, then wake and vector
   task automatic t_sleep();
      int n;
      wr(ADDR_ENABLES, 8'h40);
      global_irq_enable_i <= 1'b1;
      wr(ADDR_CTRL_ZERO, c0(2'b11, 2, 1'b0, 1'b1));
      repeat (8) @(posedge clk_i);
      wr(ADDR_CTRL_ZERO, c0(2'b11, 2, 1'b1, 1'b1));
      sleep_i <= 1'b1;
      #1;
      check({5'h0, irq_o, wake_o, vector_o}, 8'h00, "no early wake");
      for (n = 0; n < 300 && irq_o !== 1'b1; n++) @(posedge clk_i);
      #1;
      check({5'h0, irq_o, wake_o, vector_o}, 8'h06, "wake in sleep");
      @(posedge clk_i);
      sleep_i <= 1'b0;
      #1;
      check({7'h0, vector_o}, 8'h01, "vector awake");
      @(posedge clk_i);
      global_irq_enable_i <= 1'b0;
      #1;
      check({7'h0, vector_o}, 8'h00, "no vector without global");
      repeat (50) @(posedge clk_i);
      rdr(ADDR_FLAGS);
      check(rd, 8'h40, "flag persists");
      wr(ADDR_ENABLES, 8'h00);
      #1;
      check({7'h0, irq_o}, 8'h00, "irq off with enable off");
      rdr(ADDR_RESULT);
      check(rd, levels[23:16], "result after sleep");
      wr(ADDR_FLAGS, 8'h00);
   endtask
   // abort keeps the old result and blocks go during recovery
   task automatic t_abort();
      wr(ADDR_CTRL_ZERO, c0(2'b01, 1, 1'b0, 1'b1));
      repeat (8) @(posedge clk_i);
      wr(ADDR_CTRL_ZERO, c0(2'b01, 1, 1'b1, 1'b1));
      repeat (20) @(posedge clk_i);
      wr(ADDR_CTRL_ZERO, c0(2'b01, 1, 1'b0, 1'b1));
      wr(ADDR_CTRL_ZERO, c0(2'b01, 1, 1'b1, 1'b1));
      rdr(ADDR_CTRL_ZERO);
      check(rd, c0(2'b01, 1, 1'b0, 1'b1), "go in recovery");
      check({7'h0, sample_o}, 8'h00, "recovery holds off sampling");
      repeat (20) @(posedge clk_i);
      #1;
      check({7'h0, sample_o}, 8'h01, "sampling resumes");
      rdr(ADDR_RESULT);
      check(rd, levels[23:16], "old result kept");
      rdr(ADDR_FLAGS);
      check(rd, 8'h00, "no flag on abort");
   endtask
   // sleep abort on a system clock, then a flag clear landing on completion
   task automatic t_corner();
      wr(ADDR_CTRL_ZERO, c0(2'b01, 1, 1'b1, 1'b1));
      #1;
      check(trial_o, 8'h80, "first trial code");
      repeat (20) @(posedge clk_i);
      sleep_i <= 1'b1;
      @(posedge clk_i);
      sleep_i <= 1'b0;
      rdr(ADDR_CTRL_ZERO);
      check(rd, c0(2'b01, 1, 1'b0, 1'b1), "sleep abort on system clock");
      repeat (20) @(posedge clk_i);
      rdr(ADDR_RESULT);
      check(rd, levels[23:16], "sleep abort keeps result");
      wr(ADDR_CTRL_ZERO, c0(2'b00, 1, 1'b1, 1'b1));
      repeat (17) @(posedge clk_i);
      wr(ADDR_FLAGS, 8'h00);
      rdr(ADDR_FLAGS);
      check(rd, 8'h40, "completion beats flag clear");
      rdr(ADDR_RESULT);
      check(rd, levels[15:8], "result after clock switch");
      wr(ADDR_FLAGS, 8'h00);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_refused();
      t_ref_chan();
      t_convert(2'b00, 0, 1);
      t_convert(2'b01, 1, 4);
      t_convert(2'b10, 2, 16);
      t_convert(2'b11, 3, 0);
      t_sleep();
      t_abort();
      t_corner();
      give_verdict();
   end
endmodule // sar_adc_conversion_control_tb
